// *** rtl/pcs_pkg.sv ***
// constants and types shared by the command-select block
`default_nettype none
package pcs_pkg;
    // parameter indices on the fieldbus parameter port
    localparam logic [4:0] IDX_CMD = 5'h00;
    localparam logic [4:0] IDX_CYCLE = 5'h01;
    localparam logic [4:0] IDX_DELAY = 5'h02;
    localparam logic [4:0] IDX_AIN2_FN = 5'h03;
    localparam logic [4:0] IDX_AIN2_TYPE = 5'h04;
    localparam logic [4:0] IDX_DIN1_FN = 5'h05;
    localparam logic [4:0] IDX_BAKE_CUR = 5'h06;
    localparam logic [4:0] IDX_BAKE_OFF = 5'h07;
    localparam logic [4:0] IDX_BAKE_RAMP = 5'h08;
    localparam logic [4:0] IDX_DIN1_LVL = 5'h09;
    localparam logic [4:0] IDX_DIN2_LVL = 5'h0a;
    localparam logic [4:0] IDX_AIN2_VAL = 5'h0b;
    localparam logic [4:0] IDX_LINE_V = 5'h0c;
    localparam logic [4:0] IDX_ENABLE = 5'h0d;

    // command word bit positions
    localparam int CMD_SP_LOCAL_BIT = 1;
    localparam int CMD_ENABLE_BIT = 2;
    localparam int CMD_ILIM_LOCAL_BIT = 4;
    localparam int CMD_TOTAL_CLR_BIT = 11;
    localparam logic [15:0] CMD_STORE_MASK = 16'h0016;
    localparam logic [15:0] CMD_RESET = 16'h0000;

    // setting ranges and reset values
    localparam logic [15:0] CYCLE_MAX = 16'h00ff;
    localparam logic [7:0] CYCLE_RESET = 8'h1e;
    localparam logic [15:0] DELAY_MAX = 16'h005a;
    localparam logic [6:0] DELAY_RESET = 7'h3c;
    localparam logic [15:0] BAKE_CUR_MAX = 16'h5208;
    localparam logic [14:0] BAKE_CUR_RESET = 15'h0000;
    localparam logic [15:0] BAKE_MIN_LO = 16'h0001;
    localparam logic [15:0] BAKE_MIN_HI = 16'h270f;
    localparam logic [13:0] BAKE_OFF_RESET = 14'h0001;
    localparam logic [13:0] BAKE_RAMP_RESET = 14'h0001;
    localparam logic [9:0] AIN_PCT_MAX = 10'h3e8;

    // zero-cross period step
    localparam int CYCLE_STEP_MS = 50;
    localparam int CLK_KHZ = 200000;
    localparam int CYCLE_STEP_CLKS = CYCLE_STEP_MS * CLK_KHZ;

    typedef enum logic [3:0] {
        DIN_NONE,
        DIN_ENABLE,
        DIN_VOLT_FB,
        DIN_LOCAL_REMOTE,
        DIN_PHASE_ANGLE,
        DIN_SP_AIN_SEL,
        DIN_LOGGING,
        DIN_BAKEOUT,
        DIN_ALARM_RESET,
        DIN_CONTACTOR
    } pcs_din_fn_t;
    localparam logic [15:0] DIN_FN_LAST = 16'h0009;
    localparam pcs_din_fn_t DIN1_FN_RESET = DIN_VOLT_FB;

    typedef enum logic [1:0] {
        AIN2_ILIMIT,
        AIN2_FEEDBACK,
        AIN2_SETPOINT
    } pcs_ain2_fn_t;
    localparam logic [15:0] AIN2_FN_LAST = 16'h0002;

    typedef enum logic [1:0] {
        VOLTAGE_OR_POT_INPUT_TYPE,
        TYPE_4_20MA,
        TYPE_0_20MA
    } pcs_ain_type_t;
    localparam logic [15:0] AIN_TYPE_LAST = 16'h0002;
    localparam pcs_ain_type_t AIN2_TYPE_RESET = VOLTAGE_OR_POT_INPUT_TYPE;
endpackage
`default_nettype wire

// *** rtl/pcs_sync.sv ***
// two-flop synchroniser for a group of unrelated levels
`default_nettype none
module pcs_sync #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // each bit crosses on its own; no bit depends on another
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** rtl/pcs_energy.sv ***
// energy totaliser in tenths of a kWh
`default_nettype none
module pcs_energy (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic clear,
    output logic [31:0] energy_accumulator
);
    // clear wins over a same-cycle tick; saturates instead of wrapping
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            energy_accumulator <= 32'h00000000;
        else if (clear)
            energy_accumulator <= 32'h00000000;
        else if (tick && energy_accumulator != 32'hffffffff)
            energy_accumulator <= energy_accumulator + 32'h00000001;
    end
endmodule
`default_nettype wire

// *** rtl/pcs_top.sv ***
// command word, input functions and settings of the power controller
`default_nettype none
module pcs_top
    import pcs_pkg::*;
#(
    parameter int unsigned STEP_CLKS = CYCLE_STEP_CLKS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic par_wr,
    input wire logic [4:0] par_addr,
    input wire logic [15:0] par_wdata,
    input wire logic [4:0] par_rd_addr,
    output logic [15:0] par_rdata,
    output logic par_err,
    input wire logic din1_pin,
    input wire logic din2_pin,
    input wire logic port2_rw_pin,
    input wire logic has_ilimit_pin,
    input wire logic [9:0] ain2_pct,
    input wire logic [9:0] line_volts,
    input wire logic energy_tick,
    input wire logic power_request,
    output logic output_enable,
    output logic power_on,
    output logic sp_local,
    output logic sp_remote_from_ain2,
    output logic ilimit_local,
    output logic ain2_to_ilimit,
    output logic ain2_to_feedback,
    output logic ain2_to_setpoint,
    output logic [1:0] ain2_type,
    output logic volt_feedback_sel,
    output logic phase_angle_sel,
    output logic logging_en,
    output logic bakeout_en,
    output logic contactor_operation_mode,
    output logic hb_alarm_clear,
    output logic alarm_relay_normal,
    output logic [7:0] cycle_time,
    output logic [6:0] fire_delay,
    output logic [14:0] bake_current,
    output logic [13:0] bake_off_min,
    output logic [13:0] bake_ramp_min,
    output logic cycle_tick,
    output logic [31:0] energy_accumulator
);
    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    logic [3:0] pins_s;
    logic din1_s;
    logic din2_s;
    logic port2_rw;
    logic has_ilimit;
    logic [15:0] control_command_word_q;
    pcs_din_fn_t din1_fn_q;
    pcs_ain2_fn_t ain2_fn_q;
    logic ain2_fn_set_q;
    pcs_ain2_fn_t ain2_fn;
    pcs_ain_type_t ain2_type_q;
    logic din1_on_q;
    logic total_clear;
    logic wr_ok;
    logic [23:0] step_cnt_q;
    logic [7:0] period_cnt_q;
    logic step_tick;

    pcs_sync #(.W(4)) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({has_ilimit_pin, port2_rw_pin, din2_pin, din1_pin}),
        .sync_out(pins_s)
    );
    assign din1_s = pins_s[0];
    assign din2_s = pins_s[1];
    assign port2_rw = pins_s[2];
    assign has_ilimit = pins_s[3];

    // write acceptance: out-of-range values are refused and flagged
    always_comb
    begin
        case (par_addr)
            IDX_CMD: wr_ok = 1'b1;
            IDX_CYCLE: wr_ok = in_range(par_wdata, 16'h0000, CYCLE_MAX);
            IDX_DELAY: wr_ok = in_range(par_wdata, 16'h0000, DELAY_MAX);
            IDX_AIN2_FN: wr_ok = in_range(par_wdata, 16'h0000, AIN2_FN_LAST);
            IDX_AIN2_TYPE: wr_ok = in_range(par_wdata, 16'h0000, AIN_TYPE_LAST);
            IDX_DIN1_FN: wr_ok = in_range(par_wdata, 16'h0000, DIN_FN_LAST);
            IDX_BAKE_CUR: wr_ok = in_range(par_wdata, 16'h0000, BAKE_CUR_MAX);
            IDX_BAKE_OFF: wr_ok = in_range(par_wdata, BAKE_MIN_LO, BAKE_MIN_HI);
            IDX_BAKE_RAMP: wr_ok = in_range(par_wdata, BAKE_MIN_LO, BAKE_MIN_HI);
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            par_err <= 1'b0;
        else
            par_err <= par_wr && !wr_ok;
    end

    // only bits 1, 2 and 4 are kept; bit 11 is a command, not a state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            control_command_word_q <= CMD_RESET;
        else if (par_wr && par_addr == IDX_CMD)
            control_command_word_q <= par_wdata & CMD_STORE_MASK;
    end

    assign total_clear = par_wr && par_addr == IDX_CMD && par_wdata[CMD_TOTAL_CLR_BIT];

    pcs_energy u_energy (
        .clk(clk),
        .rst(rst),
        .tick(energy_tick),
        .clear(total_clear),
        .energy_accumulator(energy_accumulator)
    );

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cycle_time <= CYCLE_RESET;
            fire_delay <= DELAY_RESET;
            bake_current <= BAKE_CUR_RESET;
            bake_off_min <= BAKE_OFF_RESET;
            bake_ramp_min <= BAKE_RAMP_RESET;
        end
        else if (par_wr && wr_ok)
        begin
            case (par_addr)
                IDX_CYCLE: cycle_time <= par_wdata[7:0];
                IDX_DELAY: fire_delay <= par_wdata[6:0];
                IDX_BAKE_CUR: bake_current <= par_wdata[14:0];
                IDX_BAKE_OFF: bake_off_min <= par_wdata[13:0];
                IDX_BAKE_RAMP: bake_ramp_min <= par_wdata[13:0];
                default: ;
            endcase
        end
    end

    // the ain2 default depends on a strap, so it is held open until written
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            din1_fn_q <= DIN1_FN_RESET;
            ain2_fn_q <= AIN2_ILIMIT;
            ain2_fn_set_q <= 1'b0;
            ain2_type_q <= AIN2_TYPE_RESET;
        end
        else if (par_wr && wr_ok)
        begin
            case (par_addr)
                IDX_DIN1_FN: din1_fn_q <= pcs_din_fn_t'(par_wdata[3:0]);
                IDX_AIN2_FN:
                begin
                    ain2_fn_q <= pcs_ain2_fn_t'(par_wdata[1:0]);
                    ain2_fn_set_q <= 1'b1;
                end
                IDX_AIN2_TYPE: ain2_type_q <= pcs_ain_type_t'(par_wdata[1:0]);
                default: ;
            endcase
        end
    end

    always_comb
    begin
        if (ain2_fn_set_q)
            ain2_fn = ain2_fn_q;
        else if (has_ilimit)
            ain2_fn = AIN2_ILIMIT;
        else
            ain2_fn = AIN2_FEEDBACK;
    end

    assign ain2_to_ilimit = ain2_fn == AIN2_ILIMIT;
    assign ain2_to_feedback = ain2_fn == AIN2_FEEDBACK;
    assign ain2_to_setpoint = ain2_fn == AIN2_SETPOINT;
    assign ain2_type = ain2_type_q;
    assign ilimit_local = control_command_word_q[CMD_ILIM_LOCAL_BIT];

    // input 1 decode; a function other than the one chosen never sees the level
    always_comb
    begin
        if (din1_fn_q == DIN_ENABLE)
        begin
            if (port2_rw)
                output_enable = din1_s && control_command_word_q[CMD_ENABLE_BIT];
            else
                output_enable = din1_s;
        end
        else
            output_enable = control_command_word_q[CMD_ENABLE_BIT];
    end

    always_comb
    begin
        if (!port2_rw && din1_fn_q == DIN_LOCAL_REMOTE)
            sp_local = din1_s;
        else
            sp_local = control_command_word_q[CMD_SP_LOCAL_BIT];
    end

    assign power_on = power_request && output_enable;
    assign sp_remote_from_ain2 = din1_fn_q == DIN_SP_AIN_SEL && din1_s;
    assign phase_angle_sel = din1_fn_q == DIN_PHASE_ANGLE && din1_s;
    assign volt_feedback_sel = din1_fn_q == DIN_VOLT_FB && din1_s;
    assign logging_en = din1_fn_q == DIN_LOGGING && din1_s;
    assign bakeout_en = din1_fn_q == DIN_BAKEOUT && din1_s;
    assign contactor_operation_mode = din1_fn_q == DIN_CONTACTOR && din1_s;
    assign alarm_relay_normal = din1_fn_q == DIN_ALARM_RESET && din1_s;

    // heater-break clear is one pulse per rising edge of the reset input
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            din1_on_q <= 1'b0;
            hb_alarm_clear <= 1'b0;
        end
        else
        begin
            din1_on_q <= alarm_relay_normal;
            hb_alarm_clear <= alarm_relay_normal && !din1_on_q;
        end
    end

    // zero-cross period: cycle_time steps of 50 ms; zero means no period
    assign step_tick = step_cnt_q == 24'(STEP_CLKS - 1);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            step_cnt_q <= 24'h000000;
        else if (step_tick)
            step_cnt_q <= 24'h000000;
        else
            step_cnt_q <= step_cnt_q + 24'h000001;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            period_cnt_q <= 8'h00;
            cycle_tick <= 1'b0;
        end
        else
        begin
            cycle_tick <= 1'b0;
            if (cycle_time == 8'h00)
                period_cnt_q <= 8'h00;
            else if (step_tick)
            begin
                if (period_cnt_q + 8'h01 >= cycle_time)
                begin
                    period_cnt_q <= 8'h00;
                    cycle_tick <= 1'b1;
                end
                else
                    period_cnt_q <= period_cnt_q + 8'h01;
            end
        end
    end

    // read mux; unmapped indices read zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            par_rdata <= 16'h0000;
        else
        begin
            case (par_rd_addr)
                IDX_CMD: par_rdata <= control_command_word_q & CMD_STORE_MASK;
                IDX_CYCLE: par_rdata <= {8'h00, cycle_time};
                IDX_DELAY: par_rdata <= {9'h000, fire_delay};
                IDX_AIN2_FN: par_rdata <= {14'h0000, ain2_fn};
                IDX_AIN2_TYPE: par_rdata <= {14'h0000, ain2_type_q};
                IDX_DIN1_FN: par_rdata <= {12'h000, din1_fn_q};
                IDX_BAKE_CUR: par_rdata <= {1'b0, bake_current};
                IDX_BAKE_OFF: par_rdata <= {2'h0, bake_off_min};
                IDX_BAKE_RAMP: par_rdata <= {2'h0, bake_ramp_min};
                IDX_DIN1_LVL: par_rdata <= {15'h0000, din1_s};
                IDX_DIN2_LVL: par_rdata <= {15'h0000, din2_s};
                IDX_AIN2_VAL: par_rdata <= {6'h00, (ain2_pct > AIN_PCT_MAX) ? AIN_PCT_MAX
                                                                : ain2_pct};
                IDX_LINE_V: par_rdata <= {6'h00, line_volts};
                IDX_ENABLE: par_rdata <= {15'h0000, output_enable};
                default: par_rdata <= 16'h0000;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_cmd_wr_clear;
        par_wr && par_addr == IDX_CMD && par_wdata[CMD_TOTAL_CLR_BIT];
    endsequence

    sequence s_cmd_wr_keep;
        par_wr && par_addr == IDX_CMD && !par_wdata[CMD_TOTAL_CLR_BIT] && !energy_tick;
    endsequence

    a_enable_direct: assert property (din1_fn_q != DIN_ENABLE |->
        output_enable == control_command_word_q[CMD_ENABLE_BIT])
        else $error("enable not following command bit 2");
    a_enable_both: assert property (port2_rw && din1_fn_q == DIN_ENABLE &&
        !(din1_s && control_command_word_q[CMD_ENABLE_BIT]) |-> !output_enable)
        else $error("enabled without input and bit 2");
    a_power_gate: assert property (power_on |-> output_enable && power_request)
        else $error("power delivered while not enabled");
    a_sp_override: assert property (port2_rw |->
        sp_local == control_command_word_q[CMD_SP_LOCAL_BIT])
        else $error("set point source ignores bit 1 on rw port");
    a_din_none: assert property (din1_fn_q == DIN_NONE && $changed(din1_s) |->
        $stable(sp_local) && $stable(output_enable))
        else $error("input 1 level acted with function none");
    a_total_clear: assert property (s_cmd_wr_clear |=>
        energy_accumulator == 32'h00000000)
        else $error("totaliser not cleared");
    a_total_keep: assert property (s_cmd_wr_keep |=> $stable(energy_accumulator))
        else $error("totaliser changed on bit 11 zero");
    a_cycle_range: assert property (par_wr && par_addr == IDX_CYCLE &&
        par_wdata > CYCLE_MAX |=> $stable(cycle_time) && par_err)
        else $error("cycle time out of range accepted");
    a_delay_range: assert property (par_wr && par_addr == IDX_DELAY &&
        par_wdata > DELAY_MAX |=> $stable(fire_delay))
        else $error("delay out of range accepted");
    a_bake_floor: assert property (par_wr && par_addr == IDX_BAKE_OFF &&
        par_wdata == 16'h0000 |=> $stable(bake_off_min) ##1 bake_off_min != 14'h0000)
        else $error("bakeout off time zero accepted");
    a_unused_zero: assert property (par_rd_addr == IDX_CMD |=>
        (par_rdata & ~CMD_STORE_MASK) == 16'h0000)
        else $error("unused command bits read nonzero");
    a_ain2_clamp: assert property (par_rd_addr == IDX_AIN2_VAL |=>
        par_rdata <= {6'h00, AIN_PCT_MAX})
        else $error("analog input 2 reading above full scale");
endmodule
`default_nettype wire

// *** bench/pcs_field.sv ***
// field-side model: digital inputs, straps, analog levels and energy pulses
`default_nettype none
module pcs_field (
    input wire logic clk,
    input wire logic tick_en,
    input wire logic [3:0] lvl,
    input wire logic [9:0] ain_set,
    input wire logic [9:0] volts_set,
    output logic din1_pin,
    output logic din2_pin,
    output logic port2_rw_pin,
    output logic has_ilimit_pin,
    output logic [9:0] ain2_pct,
    output logic [9:0] line_volts,
    output logic energy_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_q = 2'h0;
    initial
    begin
        {has_ilimit_pin, port2_rw_pin, din2_pin, din1_pin} = 4'h8;
        ain2_pct = 10'h000;
        line_volts = 10'h000;
        energy_tick = 1'b0;
    end
    // metering pulses come every third cycle, never two in a row
    always @(posedge clk)
    begin
        ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
        energy_tick <= tick_en && (ph_q == 2'h0);
        {has_ilimit_pin, port2_rw_pin, din2_pin, din1_pin} <= lvl;
        ain2_pct <= ain_set;
        line_volts <= volts_set;
    end
endmodule
`default_nettype wire

// *** bench/test_power_control_command_select.sv ***
// self-checking bench for the command-select block
`default_nettype none
module test_power_control_command_select
    import pcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEP = 4;
    typedef struct {int k; logic [31:0] v;} pcs_note_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic par_wr = 1'b0;
    logic [4:0] par_addr = 5'h00;
    logic [15:0] par_wdata = 16'h0000;
    logic [4:0] par_rd_addr = 5'h00;
    logic power_request = 1'b0;
    logic tick_en = 1'b0;
    logic [3:0] lvl = 4'h8;
    logic [9:0] ain_set = 10'h000;
    logic [9:0] volts_set = 10'h000;
    logic [15:0] par_rdata;
    logic par_err, din1_pin, din2_pin, port2_rw_pin, has_ilimit_pin, energy_tick, cycle_tick;
    logic [9:0] ain2_pct, line_volts;
    logic output_enable, power_on, sp_local, sp_remote_from_ain2, ilimit_local;
    logic ain2_to_ilimit, ain2_to_feedback, ain2_to_setpoint, volt_feedback_sel;
    logic phase_angle_sel, logging_en, bakeout_en, contactor_operation_mode, alarm_relay_normal;
    logic [1:0] ain2_type;
    logic [7:0] cycle_time;
    logic [6:0] fire_delay;
    logic [31:0] energy_accumulator;
    logic hb_alarm_clear;
    wire logic [13:0] flags_seen = {output_enable, power_on, sp_local, sp_remote_from_ain2,
        ilimit_local, ain2_to_ilimit, ain2_to_feedback, ain2_to_setpoint, volt_feedback_sel,
        phase_angle_sel, logging_en, bakeout_en, contactor_operation_mode, alarm_relay_normal};
    pcs_note_t exp_q[$];
    pcs_note_t nt;
    int n_mismatch = 0;
    int compares = 0;
    int seed = 32'he18c;
    int n_tick = 0;
    int n_hb = 0;
    int g;
    logic [15:0] dflt [9] = '{16'h0000, 16'h001e, 16'h003c, 16'h0000, 16'h0000, 16'h0002,
        16'h0000, 16'h0001, 16'h0001};
    logic [4:0] ri [8] = '{IDX_CYCLE, IDX_DELAY, IDX_BAKE_CUR, IDX_BAKE_OFF, IDX_BAKE_RAMP,
        IDX_DIN1_FN, IDX_AIN2_FN, IDX_AIN2_TYPE};
    logic [15:0] rgood [8] = '{16'h00ff, 16'h005a, 16'h5208, 16'h270f, 16'h0001, 16'h0009,
        16'h0002, 16'h0002};
    logic [15:0] rbad [8] = '{16'h0100, 16'h005b, 16'h5209, 16'h2710, 16'h0000, 16'h000a,
        16'h0003, 16'h0003};
    logic [3:0] fn_m;
    logic [15:0] cmd_m;
    logic [13:0] f;
    logic [9:0] a;
    logic d1, p2, req;

    always #2.5 clk = ~clk;

    pcs_top #(.STEP_CLKS(STEP)) uut (
        .clk, .rst, .par_wr, .par_addr, .par_wdata, .par_rd_addr, .par_rdata, .par_err,
        .din1_pin, .din2_pin, .port2_rw_pin, .has_ilimit_pin, .ain2_pct, .line_volts,
        .energy_tick, .power_request, .output_enable, .power_on, .sp_local,
        .sp_remote_from_ain2, .ilimit_local, .ain2_to_ilimit, .ain2_to_feedback,
        .ain2_to_setpoint, .ain2_type, .volt_feedback_sel, .phase_angle_sel, .logging_en,
        .bakeout_en, .contactor_operation_mode, .hb_alarm_clear, .alarm_relay_normal,
        .cycle_time, .fire_delay, .bake_current(), .bake_off_min(), .bake_ramp_min(),
        .cycle_tick, .energy_accumulator
    );
    pcs_field field (
        .clk, .tick_en, .lvl, .ain_set, .volts_set, .din1_pin, .din2_pin, .port2_rw_pin,
        .has_ilimit_pin, .ain2_pct, .line_volts, .energy_tick
    );

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
            n_mismatch++;
        end
    endtask
    task automatic note(input int k, input logic [31:0] v);
        exp_q.push_back('{k, v});
    endtask
    task automatic wr(input logic [4:0] ad, input logic [15:0] d, input logic e);
        @(posedge clk);
        par_wr <= 1'b1;
        par_addr <= ad;
        par_wdata <= d;
        @(posedge clk);
        par_wr <= 1'b0;
        note(2, {31'h0, e});
    endtask
    task automatic rd(input logic [4:0] ad, input logic [15:0] e);
        @(posedge clk);
        par_rd_addr <= ad;
        @(posedge clk);
        note(0, {16'h0, e});
    endtask
    // enable: input alone without secondary rw, both needed with it
    function automatic logic [13:0] flags(input logic [3:0] fn, input logic d, input logic p,
        input logic [15:0] c, input logic rq);
        logic en;
        logic spl;
        en = (fn == DIN_ENABLE) ? (p ? (d & c[2]) : d) : c[2];
        spl = (fn == DIN_LOCAL_REMOTE && !p) ? d : c[1];
        return {en, en & rq, spl, fn == DIN_SP_AIN_SEL && d, c[4], 3'b001,
            fn == DIN_VOLT_FB && d, fn == DIN_PHASE_ANGLE && d, fn == DIN_LOGGING && d,
            fn == DIN_BAKEOUT && d, fn == DIN_CONTACTOR && d, fn == DIN_ALARM_RESET && d};
    endfunction
    // bounded: a missing tick gives a gap of 200, which then mismatches
    task automatic gap(output int gg);
        int n;
        n = 0;
        // start on a falling edge so the tick is never read as it launches
        @(negedge clk);
        while (cycle_tick !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        gg = 1;
        while (cycle_tick !== 1'b1 && gg < 200)
        begin
            @(negedge clk);
            gg++;
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(negedge clk)
    begin
        if (energy_tick === 1'b1)
            n_tick++;
        if (hb_alarm_clear === 1'b1)
            n_hb++;
        while (exp_q.size() > 0)
        begin
            nt = exp_q.pop_front();
            case (nt.k)
                0: check("par_rdata", {16'h0, par_rdata}, nt.v);
                1: check("flags", {18'h0, flags_seen}, nt.v);
                2: check("par_err", {31'h0, par_err}, nt.v);
                3: check("energy", energy_accumulator, nt.v);
                default: check("settings", {15'h0, cycle_time, fire_delay, ain2_type}, nt.v);
            endcase
        end
    end

    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++)
            rd(i[4:0], dflt[i]);
        rd(5'h1f, 16'h0000);
        wr(5'h1f, 16'h1234, 1'b1);
        wr(IDX_AIN2_VAL, 16'h0001, 1'b1);
        lvl <= 4'h0;
        repeat (4) @(posedge clk);
        rd(IDX_AIN2_FN, 16'h0001);
        $display("test defaults done");
        for (int i = 0; i < 8; i++)
        begin
            wr(ri[i], rgood[i], 1'b0);
            rd(ri[i], rgood[i]);
            wr(ri[i], rbad[i], 1'b1);
            rd(ri[i], rgood[i]);
        end
        wr(IDX_BAKE_OFF, 16'h0000, 1'b1);
        rd(IDX_BAKE_OFF, 16'h270f);
        note(4, {15'h0, 8'hff, 7'h5a, 2'h2});
        $display("test ranges done");
        wr(IDX_CYCLE, 16'h0003, 1'b0);
        gap(g);
        check("tick gap", g, 3 * STEP);
        wr(IDX_CYCLE, 16'h0000, 1'b0);
        n_tick = 0;
        g = 0;
        // a tick launched with the old setting may still stand one cycle
        @(negedge clk);
        repeat (60)
        begin
            @(negedge clk);
            if (cycle_tick === 1'b1)
                g++;
        end
        check("ticks at zero", g, 0);
        $display("test cycle done");
        for (int i = 0; i < 40; i++)
        begin
            fn_m = 4'(i % 10);
            cmd_m = 16'($random(seed));
            {d1, p2, req} = 3'($random(seed));
            lvl <= {1'b1, p2, ~d1, d1};
            power_request <= req;
            wr(IDX_DIN1_FN, {12'h0, fn_m}, 1'b0);
            wr(IDX_CMD, cmd_m, 1'b0);
            repeat (3) @(posedge clk);
            f = flags(fn_m, d1, p2, cmd_m, req);
            note(1, {18'h0, f});
            rd(IDX_CMD, cmd_m & 16'h0016);
            rd(IDX_DIN1_LVL, {15'h0, d1});
            rd(IDX_DIN2_LVL, {15'h0, ~d1});
            rd(IDX_ENABLE, {15'h0, f[13]});
        end
        lvl <= 4'h8;
        repeat (4) @(posedge clk);
        wr(IDX_DIN1_FN, {12'h0, DIN_ALARM_RESET}, 1'b0);
        repeat (4) @(posedge clk);
        n_hb = 0;
        for (int i = 0; i < 2; i++)
        begin
            lvl <= 4'h9;
            repeat (6) @(posedge clk);
            lvl <= 4'h8;
            repeat (6) @(posedge clk);
        end
        check("hb_alarm_clear", n_hb, 2);
        $display("test functions done");
        for (int i = 0; i < 6; i++)
        begin
            a = (i == 0) ? 10'h3ff : (i == 1) ? 10'h3e8 : 10'($random(seed));
            ain_set <= a;
            volts_set <= ~a;
            repeat (3) @(posedge clk);
            rd(IDX_AIN2_VAL, (a > 10'h3e8) ? 16'h03e8 : {6'h0, a});
            rd(IDX_LINE_V, {6'h0, ~a});
        end
        $display("test analog done");
        tick_en <= 1'b1;
        repeat (30) @(posedge clk);
        tick_en <= 1'b0;
        repeat (4) @(posedge clk);
        wr(IDX_CMD, 16'h0800, 1'b0);
        n_tick = 0;
        note(3, 32'h0);
        tick_en <= 1'b1;
        repeat (30) @(posedge clk);
        tick_en <= 1'b0;
        repeat (4) @(posedge clk);
        wr(IDX_CMD, 16'h0000, 1'b0);
        note(3, n_tick);
        rd(IDX_CMD, 16'h0000);
        $display("test energy done");
        repeat (2) @(posedge clk);
        conclude();
    end
endmodule
`default_nettype wire
